/* src/fsic_ctrl.sv */
// five source interrupt controller: ram bit flags, priority, entry sequence
`timescale 1ns/1ps
`include "fsic_consts.svh"
module fsic_ctrl
  import fsic_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire fsic_pkg::fsic_bitop_t      bitOp,
  output logic                            testData_q,
  input  wire logic                       extIrqPin_n,
  input  wire logic                       extPinSelect,
  input  wire fsic_pkg::fsic_events_t     events,
  input  wire logic                       returnFromInterrupt,
  input  wire logic                       stackCarry,
  input  wire logic                       stackStatus,
  output logic                            flagRestore_q,
  output logic                            carryFlag_q,
  output logic                            branchStatusFlag_q,
  output fsic_pkg::fsic_entry_t           entry,
  output logic [`FSIC_PC_W-1:0]           vectorAddr_q,
  output logic                            pendingRequest,
  output logic                            globalIrqEnable
);

  logic [4:0]            flag_q, flag_d;       // request flags, priority order
  logic [4:0]            mask_q, mask_d;       // mask bits, 1 = masked
  logic                  ie_q, ie_d;           // global enable
  logic                  pinPrev_q, pinPrev_d; // last pin level for edge detect
  logic                  test_d;
  logic [4:0]            evt;                  // hardware set events
  logic [4:0]            flagSet, flagClr, maskSet, maskClr;
  logic                  ieSet, ieClr;
  logic [4:0]            active, grant;
  logic [`FSIC_PC_W-1:0] vecSel, vec_d;
  logic                  anyActive, accept;
  logic                  rest_d, carry_d, status_d;
  fsic_state_t           state_q, state_d;

  // true when the bit op addresses a given location and bit
  function automatic logic bitHit(input fsic_bitop_t op, input logic [1:0] l,
                                  input logic [1:0] b);
    bitHit = (op.loc == l) && (op.bitSel == b);
  endfunction

  // map all events onto the source index order
  always_comb begin
    evt = 5'h00;
    evt[`FSIC_SRC_EXT]  = extPinSelect & pinPrev_q & ~extIrqPin_n;
    evt[`FSIC_SRC_TMRB] = events.timerBOvf;
    evt[`FSIC_SRC_TMRC] = events.timerCOvf;
    evt[`FSIC_SRC_ADC]  = events.adcDone;
    evt[`FSIC_SRC_SER]  = events.serialDone;
  end

  // decode bit set/reset onto flags, masks and enable
  always_comb begin
    flagSet = 5'h00;
    flagClr = 5'h00;
    maskSet = 5'h00;
    maskClr = 5'h00;
    ieSet   = bitOp.setReq & bitHit(bitOp, `FSIC_LOC_EXT, `FSIC_BIT_IE);
    ieClr   = bitOp.clrReq & bitHit(bitOp, `FSIC_LOC_EXT, `FSIC_BIT_IE);
    flagSet[`FSIC_SRC_EXT]  = bitHit(bitOp, `FSIC_LOC_EXT, `FSIC_BIT_EXT_FLG);
    maskSet[`FSIC_SRC_EXT]  = bitHit(bitOp, `FSIC_LOC_EXT, `FSIC_BIT_EXT_MSK);
    flagSet[`FSIC_SRC_TMRB] = bitHit(bitOp, `FSIC_LOC_TMR, `FSIC_BIT_LO_FLG);
    maskSet[`FSIC_SRC_TMRB] = bitHit(bitOp, `FSIC_LOC_TMR, `FSIC_BIT_LO_MSK);
    flagSet[`FSIC_SRC_TMRC] = bitHit(bitOp, `FSIC_LOC_TMR, `FSIC_BIT_HI_FLG);
    maskSet[`FSIC_SRC_TMRC] = bitHit(bitOp, `FSIC_LOC_TMR, `FSIC_BIT_HI_MSK);
    flagSet[`FSIC_SRC_ADC]  = bitHit(bitOp, `FSIC_LOC_ADSER, `FSIC_BIT_LO_FLG);
    maskSet[`FSIC_SRC_ADC]  = bitHit(bitOp, `FSIC_LOC_ADSER, `FSIC_BIT_LO_MSK);
    flagSet[`FSIC_SRC_SER]  = bitHit(bitOp, `FSIC_LOC_ADSER, `FSIC_BIT_HI_FLG);
    maskSet[`FSIC_SRC_SER]  = bitHit(bitOp, `FSIC_LOC_ADSER, `FSIC_BIT_HI_MSK);
    // address hits turned into strobes; a set on a flag is simply dropped
    flagClr = flagSet & {5{bitOp.clrReq}};
    maskClr = maskSet & {5{bitOp.clrReq}};
    maskSet = maskSet & {5{bitOp.setReq}};
  end

  // bit test read mux, unmapped bits read zero
  always_comb begin
    test_d = 1'b0;
    if (bitOp.testReq) begin
      case (bitOp.loc)
        `FSIC_LOC_EXT: begin
          test_d = bitOp.bitSel == `FSIC_BIT_IE      ? ie_q :
                   bitOp.bitSel == `FSIC_BIT_EXT_FLG ? flag_q[`FSIC_SRC_EXT] :
                   bitOp.bitSel == `FSIC_BIT_EXT_MSK ? mask_q[`FSIC_SRC_EXT] : 1'b0;
        end
        `FSIC_LOC_TMR: begin
          test_d = bitOp.bitSel[1] ?
                   (bitOp.bitSel[0] ? mask_q[`FSIC_SRC_TMRC] : flag_q[`FSIC_SRC_TMRC]) :
                   (bitOp.bitSel[0] ? mask_q[`FSIC_SRC_TMRB] : flag_q[`FSIC_SRC_TMRB]);
        end
        `FSIC_LOC_ADSER: begin
          test_d = bitOp.bitSel[1] ?
                   (bitOp.bitSel[0] ? mask_q[`FSIC_SRC_SER] : flag_q[`FSIC_SRC_SER]) :
                   (bitOp.bitSel[0] ? mask_q[`FSIC_SRC_ADC] : flag_q[`FSIC_SRC_ADC]);
        end
        default: begin
          test_d = 1'b0;
        end
      endcase
    end
  end

  // a source counts only with flag set and mask clear
  assign active         = flag_q & ~mask_q;
  assign pendingRequest = anyActive;        // standby wake does not look at enable
  assign accept         = (state_q == ST_IDLE) & ie_q & anyActive;

  // fixed priority decode; vector picked at acceptance
  fsic_prio uPrio (
    .active    (active),
    .grant     (grant),
    .vector    (vecSel),
    .anyActive (anyActive)
  );

  // flag, mask and enable next values
  always_comb begin
    flag_d    = (flag_q & ~flagClr) | evt; // set wins over a clear in the same cycle
    mask_d    = (mask_q & ~maskClr) | maskSet;
    pinPrev_d = extIrqPin_n;
    ie_d      = ie_q;
    if (ieSet | returnFromInterrupt) begin
      ie_d = 1'b1;
    end
    if (ieClr) begin
      ie_d = 1'b0;
    end
    if (state_q == ST_CYC2) begin
      ie_d = 1'b0; // entry wins over any write
    end
  end

  // entry sequence: finish, push flags, push pc and jump
  always_comb begin
    state_d = state_q;
    vec_d   = vectorAddr_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_CYC1;
          vec_d   = vecSel;
        end
      end
      ST_CYC1: begin
        state_d = ST_CYC2;
      end
      ST_CYC2: begin
        state_d = ST_CYC3;
      end
      ST_CYC3: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE; // recover from a broken one-hot code
      end
    endcase
  end

  // strobes are decoded straight from the state
  always_comb begin
    entry.finishInstr = state_q == ST_CYC1;
    entry.pushFlags   = state_q == ST_CYC2;
    entry.pushPc      = (state_q == ST_CYC2) | (state_q == ST_CYC3);
    entry.loadVector  = state_q == ST_CYC3;
  end

  // interrupt return hands back the stacked carry and status
  always_comb begin
    rest_d   = returnFromInterrupt;
    carry_d  = returnFromInterrupt ? stackCarry  : carryFlag_q;
    status_d = returnFromInterrupt ? stackStatus : branchStatusFlag_q;
  end

  assign globalIrqEnable = ie_q;

  // register everything; synchronous reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_q             <= `FSIC_RST_FLAGS;
      mask_q             <= `FSIC_RST_MASKS;
      ie_q               <= `FSIC_RST_IE;
      pinPrev_q          <= 1'b1;
      testData_q         <= 1'b0;
      state_q            <= ST_IDLE;
      vectorAddr_q       <= `FSIC_VEC_EXT;
      flagRestore_q      <= 1'b0;
      carryFlag_q        <= 1'b0;
      branchStatusFlag_q <= 1'b1;
    end else begin
      flag_q             <= flag_d;
      mask_q             <= mask_d;
      ie_q               <= ie_d;
      pinPrev_q          <= pinPrev_d;
      testData_q         <= test_d;
      state_q            <= state_d;
      vectorAddr_q       <= vec_d;
      flagRestore_q      <= rest_d;
      carryFlag_q        <= carry_d;
      branchStatusFlag_q <= status_d;
    end
  end

  // checks on the entry sequence and flag handling
  sequence entrySteps_s;
    entry.finishInstr ##1 (entry.pushFlags && entry.pushPc) ##1
      (entry.pushPc && entry.loadVector);
  endsequence

  sequence ieDrop_s;
    (state_q == ST_CYC2) ##1 !ie_q;
  endsequence

  entry_order_a: assert property (@(posedge clk) disable iff (sys_rst)
    accept |=> entrySteps_s ##1 (state_q == ST_IDLE))
    else $error("entry sequence out of order");
  ie_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    accept |=> ie_q ##1 ieDrop_s)
    else $error("enable not cleared after two cycles");
  reset_values_a: assert property (@(posedge clk)
    sys_rst |=> (flag_q == 5'h00) && (mask_q == 5'h1F) && !ie_q)
    else $error("wrong reset values");
  no_sw_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    ((flagSet & ~flag_q & ~evt) == flagSet) && (flagSet != 5'h00) && bitOp.setReq
    |=> ((flag_q & $past(flagSet)) == 5'h00))
    else $error("software set a request flag");
  gate_accept_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_IDLE) && (!ie_q || ((flag_q & ~mask_q) == 5'h00))
    |=> (state_q == ST_IDLE))
    else $error("entry without enabled unmasked request");
  prio_grant_a: assert property (@(posedge clk) disable iff (sys_rst)
    accept |-> (grant == (active & (~active + 5'h01))))
    else $error("priority grant wrong");
  vector_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    accept |-> ##3 (entry.loadVector && vectorAddr_q == $past(vecSel, 3)))
    else $error("vector not loaded in third cycle");
  ext_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
    extPinSelect && pinPrev_q && !extIrqPin_n |=> flag_q[`FSIC_SRC_EXT])
    else $error("pin edge did not set flag");
  timer_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    events.timerBOvf |=> flag_q[`FSIC_SRC_TMRB])
    else $error("timer b overflow lost");
  timer_c_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    events.timerCOvf |=> flag_q[`FSIC_SRC_TMRC])
    else $error("timer c overflow lost");
  reti_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
    returnFromInterrupt && (state_q != ST_CYC2) && !ieClr |=> ie_q)
    else $error("return did not set enable");
  flag_restore_a: assert property (@(posedge clk) disable iff (sys_rst)
    returnFromInterrupt |=> flagRestore_q && (carryFlag_q == $past(stackCarry))
      && (branchStatusFlag_q == $past(stackStatus)))
    else $error("flags not restored on return");
  push_window_a: assert property (@(posedge clk) disable iff (sys_rst)
    entry.pushPc |-> (state_q == ST_CYC2) || (state_q == ST_CYC3))
    else $error("push outside cycles two and three");
endmodule

/* src/fsic_consts.svh */
// constants for the five source interrupt controller: bit map, resets, vectors
`ifndef FSIC_CONSTS_SVH
`define FSIC_CONSTS_SVH

// number of request sources, index order equals priority order
`define FSIC_NUM_SRC      5
`define FSIC_SRC_EXT      0
`define FSIC_SRC_TMRB     1
`define FSIC_SRC_TMRC     2
`define FSIC_SRC_ADC      3
`define FSIC_SRC_SER      4

// ram bit locations of the control bits
`define FSIC_LOC_EXT      2'h0
`define FSIC_LOC_TMR      2'h2
`define FSIC_LOC_ADSER    2'h3

// bit positions inside a location
`define FSIC_BIT_IE       2'h0
`define FSIC_BIT_EXT_FLG  2'h2
`define FSIC_BIT_EXT_MSK  2'h3
`define FSIC_BIT_LO_FLG   2'h0
`define FSIC_BIT_LO_MSK   2'h1
`define FSIC_BIT_HI_FLG   2'h2
`define FSIC_BIT_HI_MSK   2'h3

// reset values
`define FSIC_RST_IE       1'h0
`define FSIC_RST_FLAGS    5'h00
`define FSIC_RST_MASKS    5'h1F

// vector addresses, program counter width
`define FSIC_PC_W         14
`define FSIC_VEC_EXT      14'h0002
`define FSIC_VEC_TMRB     14'h0004
`define FSIC_VEC_TMRC     14'h0006
`define FSIC_VEC_ADC      14'h0008
`define FSIC_VEC_SER      14'h000A

`endif

/* src/fsic_pkg.sv */
// types shared by the interrupt controller files
package fsic_pkg;
  `include "fsic_consts.svh"

  // entry sequence states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CYC1 = 4'h2,
    ST_CYC2 = 4'h4,
    ST_CYC3 = 4'h8
  } fsic_state_t;

  // bit set / reset / test request from the cpu core
  typedef struct packed {
    logic [1:0] loc;
    logic [1:0] bitSel;
    logic       setReq;
    logic       clrReq;
    logic       testReq;
  } fsic_bitop_t;

  // one-cycle hardware events from the peripherals
  typedef struct packed {
    logic timerBOvf;
    logic timerCOvf;
    logic adcDone;
    logic serialDone;
  } fsic_events_t;

  // entry sequence strobes towards the cpu sequencer
  typedef struct packed {
    logic finishInstr;
    logic pushFlags;
    logic pushPc;
    logic loadVector;
  } fsic_entry_t;
endpackage

/* src/fsic_prio.sv */
// fixed priority decode of active requests into grant and vector
`timescale 1ns/1ps
`include "fsic_consts.svh"
module fsic_prio
  import fsic_pkg::*;
(
  input  wire logic [4:0]            active,
  output logic      [4:0]            grant,
  output logic      [`FSIC_PC_W-1:0] vector,
  output logic                       anyActive
);
  // lowest index wins: ext, timer b, timer c, adc, serial
  always_comb begin
    grant     = 5'h00;
    vector    = `FSIC_VEC_SER;
    anyActive = |active;
    if (active[`FSIC_SRC_EXT]) begin
      grant[`FSIC_SRC_EXT] = 1'b1;
      vector = `FSIC_VEC_EXT;
    end else if (active[`FSIC_SRC_TMRB]) begin
      grant[`FSIC_SRC_TMRB] = 1'b1;
      vector = `FSIC_VEC_TMRB;
    end else if (active[`FSIC_SRC_TMRC]) begin
      grant[`FSIC_SRC_TMRC] = 1'b1;
      vector = `FSIC_VEC_TMRC;
    end else if (active[`FSIC_SRC_ADC]) begin
      grant[`FSIC_SRC_ADC] = 1'b1;
      vector = `FSIC_VEC_ADC;
    end else if (active[`FSIC_SRC_SER]) begin
      grant[`FSIC_SRC_SER] = 1'b1;
      vector = `FSIC_VEC_SER;
    end
  end
endmodule

/* test/fsic_cpu_partner.sv */
// peripheral event sources and cpu return stub facing the interrupt controller
`timescale 1ns/1ps
module fsic_cpu_partner
  import fsic_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic [4:0]      fireEvt,
  input  wire logic            fireRet,
  input  wire logic            popCarry,
  input  wire logic            popStatus,
  output fsic_pkg::fsic_events_t events,
  output logic                 extIrqPin_n,
  output logic                 returnFromInterrupt,
  output logic                 stackCarry,
  output logic                 stackStatus
);
  import fsic_pkg::*;

  logic [1:0] pinLowCnt_q;  // cycles the pin stays low after a fire

  // pulses last one cycle; popped flags are only valid beside the return pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      events              <= '0;
      pinLowCnt_q         <= 2'h0;
      returnFromInterrupt <= 1'h0;
      stackCarry          <= 1'h0;
      stackStatus         <= 1'h0;
    end else begin
      // one overflow or completion pulse per fire, msb first
      events              <= {fireEvt[1], fireEvt[2], fireEvt[3], fireEvt[4]};
      // pin pulled low two cycles, then released to its pull-up level
      if (fireEvt[0]) begin
        pinLowCnt_q <= 2'h2;
      end else if (pinLowCnt_q != 2'h0) begin
        pinLowCnt_q <= pinLowCnt_q - 2'h1;
      end
      returnFromInterrupt <= fireRet;
      // outside a return the stack lines toggle, so a stale value never looks valid
      stackCarry          <= fireRet ? popCarry : ~stackCarry;
      stackStatus         <= fireRet ? popStatus : ~stackStatus;
    end
  end

  // idle high: a falling edge only while a fire is in progress
  assign extIrqPin_n = (pinLowCnt_q == 2'h0);
endmodule

/* test/fsic_ctrl_tb.sv */
// self-checking bench for the five source interrupt controller
`timescale 1ns/1ps
`include "fsic_consts.svh"
module fsic_ctrl_tb;
  import fsic_pkg::*;

  logic          clk = 1'h0;
  logic          sys_rst = 1'h1;
  fsic_bitop_t   bitOp = '0;
  logic          extPinSelect = 1'h0;
  logic [4:0]    fireEvt = 5'h00;
  logic          fireRet = 1'h0;
  logic          popCarry = 1'h0;
  logic          popStatus = 1'h0;
  logic          testData_q, extIrqPin_n, returnFromInterrupt, stackCarry, stackStatus;
  logic          flagRestore_q, carryFlag_q, branchStatusFlag_q, pendingRequest;
  logic          globalIrqEnable;
  fsic_events_t  events;
  fsic_entry_t   entry;
  logic [13:0]   vectorAddr_q;
  logic          td;                       // last bit test result
  int            failures = 0;
  int            cmp_count = 0;
  // per source, in priority order: flag location, flag bit (mask is one above), vector
  logic [1:0]    srcLoc [5] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [1:0]    srcBit [5] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h2};
  logic [13:0]   srcVec [5] = '{`FSIC_VEC_EXT, `FSIC_VEC_TMRB, `FSIC_VEC_TMRC,
                                `FSIC_VEC_ADC, `FSIC_VEC_SER};
  logic [3:0]    rstMap [4] = '{4'h8, 4'h0, 4'hA, 4'hA};  // bits after reset, per location
  localparam logic [2:0] SET = 3'h4;
  localparam logic [2:0] CLR = 3'h2;
  localparam logic [2:0] TST = 3'h1;

  fsic_ctrl u_fsic_ctrl (.clk(clk), .sys_rst(sys_rst), .bitOp(bitOp), .testData_q(testData_q),
    .extIrqPin_n(extIrqPin_n), .extPinSelect(extPinSelect), .events(events),
    .returnFromInterrupt(returnFromInterrupt), .stackCarry(stackCarry),
    .stackStatus(stackStatus), .flagRestore_q(flagRestore_q), .carryFlag_q(carryFlag_q),
    .branchStatusFlag_q(branchStatusFlag_q), .entry(entry), .vectorAddr_q(vectorAddr_q),
    .pendingRequest(pendingRequest), .globalIrqEnable(globalIrqEnable));

  fsic_cpu_partner u_fsic_cpu_partner (.clk(clk), .sys_rst(sys_rst), .fireEvt(fireEvt),
    .fireRet(fireRet), .popCarry(popCarry), .popStatus(popStatus), .events(events),
    .extIrqPin_n(extIrqPin_n), .returnFromInterrupt(returnFromInterrupt),
    .stackCarry(stackCarry), .stackStatus(stackStatus));

  // free running clock, 10 ns period
  always #5 clk = ~clk;

  // inputs always move 1 ns after the rising edge
  task tick;
    @(posedge clk);
    #1;
  endtask

  task chk(input string name, input logic [13:0] exp, input logic [13:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask

  task resetDut;
    sys_rst = 1'h1;
    repeat (3) tick;
    sys_rst = 1'h0;
  endtask

  // one bit instruction, held one cycle, then a quiet cycle so drivers never collide
  task op(input logic [1:0] l, input logic [1:0] b, input logic [2:0] kind);
    bitOp = {l, b, kind};
    tick;
    td = testData_q;
    bitOp = '0;
    tick;
  endtask

  task testBit(input logic [1:0] l, input logic [1:0] b, input logic exp, input string name);
    op(l, b, TST);
    chk(name, {13'h0, exp}, {13'h0, td});
  endtask

  // peripherals fire, with time for the pin edge to pass
  task fire(input logic [4:0] m);
    fireEvt = m;
    tick;
    fireEvt = 5'h00;
    repeat (4) tick;
  endtask

  // entered one ns into the cycle where finishInstr must show
  task enterCheck(input logic [13:0] vec);
    chk("entry c1", 14'h0008, {10'h0, entry});
    chk("vector", vec, vectorAddr_q);
    tick;
    chk("entry c2", 14'h0006, {10'h0, entry});
    chk("enable c2", 14'h0001, {13'h0, globalIrqEnable});
    tick;
    chk("entry c3", 14'h0003, {10'h0, entry});
    chk("enable c3", 14'h0000, {13'h0, globalIrqEnable});
    chk("vector c3", vec, vectorAddr_q);
    tick;
    chk("entry idle", 14'h0000, {10'h0, entry});
  endtask

  // interrupt return with given stacked flags; enable comes back
  task retCheck(input logic c, input logic s);
    popCarry = c;
    popStatus = s;
    fireRet = 1'h1;
    tick;
    fireRet = 1'h0;
    tick;
    chk("restore pulse", 14'h0001, {13'h0, flagRestore_q});
    chk("carry", {13'h0, c}, {13'h0, carryFlag_q});
    chk("status", {13'h0, s}, {13'h0, branchStatusFlag_q});
    chk("enable ret", 14'h0001, {13'h0, globalIrqEnable});
  endtask

  task t_resetValues;
    for (int l = 0; l < 4; l++) begin
      for (int b = 0; b < 4; b++) begin
        testBit(2'(l), 2'(b), rstMap[l][b], "reset bit");
      end
    end
    chk("reset carry", 14'h0000, {13'h0, carryFlag_q});
    chk("reset status", 14'h0001, {13'h0, branchStatusFlag_q});
    chk("reset pending", 14'h0000, {13'h0, pendingRequest});
    $display("done: reset values");
  endtask

  task t_swAccess;
    op(2'h2, 2'h0, SET);
    testBit(2'h2, 2'h0, 1'h0, "sw set flag");
    op(2'h1, 2'h0, SET);
    testBit(2'h1, 2'h0, 1'h0, "unmapped bit");
    op(2'h2, 2'h1, CLR);
    testBit(2'h2, 2'h1, 1'h0, "mask clear");
    op(2'h2, 2'h1, SET);
    testBit(2'h2, 2'h1, 1'h1, "mask set");
    op(2'h0, 2'h0, SET);
    testBit(2'h0, 2'h0, 1'h1, "enable set");
    op(2'h0, 2'h0, CLR);
    testBit(2'h0, 2'h0, 1'h0, "enable clear");
    fire(5'h02);
    testBit(2'h2, 2'h0, 1'h1, "timer b flag");
    op(2'h2, 2'h0, CLR);
    testBit(2'h2, 2'h0, 1'h0, "sw clear flag");
    // overflow and software clear land on the same edge: set must win
    fireEvt = 5'h02;
    tick;
    fireEvt = 5'h00;
    op(2'h2, 2'h0, CLR);
    testBit(2'h2, 2'h0, 1'h1, "set beats clear");
    op(2'h2, 2'h0, CLR);
    // set and clear together: mask ends set, enable ends clear
    op(2'h2, 2'h1, SET | CLR);
    testBit(2'h2, 2'h1, 1'h1, "mask set wins");
    op(2'h0, 2'h0, SET | CLR);
    testBit(2'h0, 2'h0, 1'h0, "enable clear wins");
    $display("done: software access");
  endtask

  task t_events;
    extPinSelect = 1'h0;
    fire(5'h01);
    testBit(2'h0, 2'h2, 1'h0, "pin unselected");
    extPinSelect = 1'h1;
    fire(5'h01);
    testBit(2'h0, 2'h2, 1'h1, "pin edge flag");
    fire(5'h1C);
    testBit(2'h2, 2'h2, 1'h1, "timer c flag");
    testBit(2'h3, 2'h0, 1'h1, "adc flag");
    testBit(2'h3, 2'h2, 1'h1, "serial flag");
    chk("masked pending", 14'h0000, {13'h0, pendingRequest});
    $display("done: events");
  endtask

  task t_masking;
    resetDut;
    fire(5'h04);
    op(2'h0, 2'h0, SET);
    repeat (2) tick;
    chk("masked entry", 14'h0000, {10'h0, entry});
    op(2'h2, 2'h3, CLR);
    chk("pending", 14'h0001, {13'h0, pendingRequest});
    enterCheck(`FSIC_VEC_TMRC);
    repeat (2) tick;
    chk("no reentry", 14'h0000, {10'h0, entry});
    $display("done: masking");
  endtask

  task t_priority;
    resetDut;
    fire(5'h1F);
    for (int k = 0; k < 5; k++) begin
      op(srcLoc[k], srcBit[k] + 2'h1, CLR);
    end
    op(2'h0, 2'h0, SET);
    for (int k = 0; k < 5; k++) begin
      if (k > 0) begin
        tick;
        chk("restore end", 14'h0000, {13'h0, flagRestore_q});
        chk("carry kept", {13'h0, k[0] ^ 1'h1}, {13'h0, carryFlag_q});
      end
      enterCheck(srcVec[k]);
      op(srcLoc[k], srcBit[k], CLR);
      retCheck(k[0], ~k[0]);
    end
    tick;
    chk("all served", 14'h0000, {10'h0, entry});
    chk("none pending", 14'h0000, {13'h0, pendingRequest});
    $display("done: priority");
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    failures++;
    results;
  end

  initial begin
    resetDut;
    t_resetValues;
    t_swAccess;
    t_events;
    t_masking;
    t_priority;
    results;
  end
endmodule
